// >>> core/effc_clock.sv
`include "effc_map.svh"
`default_nettype none

module effc_clock
  import effc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`EFFC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`EFFC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   int_ref_in,
  input  wire logic                   ext_ref_in,
  input  wire logic                   fll_clk_in,
  input  wire logic                   stop_req,
  output logic                        ext_ref_clock_out,
  output logic                        fixed_freq_clock,
  output logic                        fixed_freq_valid,
  output logic                        main_clock_out
);

  localparam logic [10:0] LONG_CYC  = 11'(`EFFC_EXT_LONG_CYC);
  localparam logic [10:0] SHORT_CYC = 11'(`EFFC_EXT_SHORT_CYC);

  effc_state_t s_r;
  effc_state_t s_nxt;

  // Reserved source code 11 leaves the previous mode in force.
  function automatic effc_mode_t mode_of(input effc_ctrl_t c,
                                         input effc_mode_t prev);
    effc_mode_t m;
    m = prev;
    if (c.clock_source_select == 2'h0)
    begin
      m = c.ref_select ? EFFC_MODE_ENG_INT : EFFC_MODE_ENG_EXT;
    end
    else if (c.clock_source_select == 2'h1)
    begin
      m = EFFC_MODE_BYP_INT;
    end
    else if (c.clock_source_select == 2'h2)
    begin
      m = EFFC_MODE_BYP_EXT;
    end
    return m;
  endfunction

  // Bypass thresholds are 010, 011, 100, 101 for bus divide 0 to 3.
  function automatic logic ffv_of(input effc_mode_t m,
                                  input effc_ctrl_t c);
    logic [2:0] need;
    logic       v;
    need = 3'({1'b0, c.bus_divide}) + `EFFC_FFV_MARGIN;
    if ((m == EFFC_MODE_ENG_INT) || (m == EFFC_MODE_ENG_EXT))
    begin
      v = 1'b1;
    end
    else
    begin
      v = (c.ref_divider >= need);
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] status_word(input effc_state_t s,
                                              input logic        stp);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EFFC_ST_FFV_BIT]                    = s.clk.fixed_freq_valid;
    w[`EFFC_ST_MODE_LSB +: 2]              = s.mode;
    w[`EFFC_ST_SLOW_BIT]                   = s.ext_slow;
    w[`EFFC_ST_FAST_BIT]                   = s.ext_fast;
    w[`EFFC_ST_EROUT_BIT]                  = s.clk.ext_ref_clock_out;
    w[`EFFC_ST_STOP_BIT]                   = stp;
    return w;
  endfunction

  always_comb
  begin
    logic        ref_lvl;
    logic        ref_rise;
    logic        ext_rise;
    logic        uses_ext;
    logic [31:0] wr_word;
    effc_ctrl_t  ctrl_new;
    s_nxt    = s_r;
    ref_lvl  = 1'b0;
    ref_rise = 1'b0;
    ext_rise = 1'b0;
    uses_ext = 1'b0;
    wr_word  = 32'h0000_0000;
    ctrl_new = s_r.ctrl;

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `EFFC_RESP_OKAY;
      if (s_nxt.aw_addr[7:2] == `EFFC_CTRL_OFS >> 2)
      begin
        wr_word  = merge(32'(s_r.ctrl), s_nxt.wdata, s_nxt.wstrb);
        ctrl_new = effc_ctrl_t'(wr_word[`EFFC_CTRL_W-1:0]);
        s_nxt.ctrl = ctrl_new;
      end
      else if (s_nxt.aw_addr[7:2] == `EFFC_STATUS_OFS >> 2)
      begin
        s_nxt.bresp = `EFFC_RESP_OKAY;
      end
      else
      begin
        s_nxt.bresp = `EFFC_RESP_SLVERR;
      end
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

    // Read channel: one read under way, answered the cycle after.
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `EFFC_RESP_OKAY;
      if (s_axi_araddr[7:2] == `EFFC_CTRL_OFS >> 2)
      begin
        s_nxt.rdata = 32'(s_r.ctrl);
      end
      else if (s_axi_araddr[7:2] == `EFFC_STATUS_OFS >> 2)
      begin
        s_nxt.rdata = status_word(s_r, stop_req);
      end
      else
      begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = `EFFC_RESP_SLVERR;
      end
    end
    s_nxt.arready = !s_nxt.rvalid;

    s_nxt.mode = mode_of(s_r.ctrl, s_r.mode);

    // FLL reference: internal select leaves the external path unused.
    ref_lvl     = s_r.ctrl.ref_select ? int_ref_in : ext_ref_in;
    ref_rise    = ref_lvl && !s_r.ref_q;
    s_nxt.ref_q = ref_lvl;
    if (ref_rise)
    begin
      s_nxt.ref_cnt = s_r.ref_cnt + 7'h01;
    end

    // Range watch on the external reference only while the FLL uses it.
    uses_ext    = !s_r.ctrl.ref_select;
    ext_rise    = ext_ref_in && !s_r.ext_q;
    s_nxt.ext_q = ext_ref_in;
    if (ext_rise)
    begin
      s_nxt.ext_per  = 11'h000;
      s_nxt.ext_fast = uses_ext && (s_r.ext_per + 11'h001 < SHORT_CYC);
      s_nxt.ext_slow = 1'b0;
    end
    else if (s_r.ext_per < LONG_CYC)
    begin
      s_nxt.ext_per = s_r.ext_per + 11'h001;
    end
    else
    begin
      s_nxt.ext_slow = uses_ext;
    end
    if (!uses_ext)
    begin
      s_nxt.ext_fast = 1'b0;
      s_nxt.ext_slow = 1'b0;
    end

    // Secondary output runs in stop only with both enables set.
    s_nxt.clk.ext_ref_clock_out = ext_ref_in
      && s_r.ctrl.ext_ref_out_enable
      && (!stop_req || s_r.ctrl.ext_ref_stop_enable);

    // Divide by two to the power of the divider; zero passes through.
    if (stop_req)
    begin
      s_nxt.clk.fixed_freq_clock = 1'b0;
    end
    else if (s_r.ctrl.ref_divider == 3'h0)
    begin
      s_nxt.clk.fixed_freq_clock = ref_lvl;
    end
    else
    begin
      s_nxt.clk.fixed_freq_clock =
        s_r.ref_cnt[s_r.ctrl.ref_divider - 3'h1];
    end

    // Flag follows the stored control fields and the mode they select now, not last cycle's mode.
    s_nxt.clk.fixed_freq_valid =
      ffv_of(mode_of(s_r.ctrl, s_r.mode), s_r.ctrl);

    // All clocks but the enabled secondary output halt in stop.
    if (stop_req)
    begin
      s_nxt.clk.main_clock_out = 1'b0;
    end
    else
    begin
      case (s_nxt.mode)
        EFFC_MODE_ENG_INT: s_nxt.clk.main_clock_out = fll_clk_in;
        EFFC_MODE_ENG_EXT: s_nxt.clk.main_clock_out = fll_clk_in;
        EFFC_MODE_BYP_INT: s_nxt.clk.main_clock_out = int_ref_in;
        EFFC_MODE_BYP_EXT: s_nxt.clk.main_clock_out = ext_ref_in;
        default:           s_nxt.clk.main_clock_out = fll_clk_in;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r                      <= '0;
      s_r.ctrl                 <= effc_ctrl_t'(`EFFC_CTRL_RST);
      s_r.mode                 <= EFFC_MODE_ENG_INT;
      s_r.awready              <= 1'b1;
      s_r.wready               <= 1'b1;
      s_r.arready              <= 1'b1;
      s_r.clk.fixed_freq_valid <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready     = s_r.awready;
  assign s_axi_wready      = s_r.wready;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_arready     = s_r.arready;
  assign s_axi_rvalid      = s_r.rvalid;
  assign s_axi_rdata       = s_r.rdata;
  assign s_axi_rresp       = s_r.rresp;
  assign ext_ref_clock_out = s_r.clk.ext_ref_clock_out;
  assign fixed_freq_clock  = s_r.clk.fixed_freq_clock;
  assign fixed_freq_valid  = s_r.clk.fixed_freq_valid;
  assign main_clock_out    = s_r.clk.main_clock_out;

endmodule // effc_clock

`default_nettype wire

// >>> core/effc_map.svh
`ifndef EFFC_MAP_SVH
`define EFFC_MAP_SVH

`define EFFC_ADDR_W        8
`define EFFC_CTRL_OFS      8'h00
`define EFFC_STATUS_OFS    8'h04

`define EFFC_CSRC_LSB      0
`define EFFC_RSEL_BIT      2
`define EFFC_REFDIV_LSB    3
`define EFFC_BUSDIV_LSB    6
`define EFFC_EROE_BIT      8
`define EFFC_ERSE_BIT      9
`define EFFC_CTRL_W        10

`define EFFC_CTRL_RST      10'h004

`define EFFC_ST_FFV_BIT    0
`define EFFC_ST_MODE_LSB   1
`define EFFC_ST_SLOW_BIT   3
`define EFFC_ST_FAST_BIT   4
`define EFFC_ST_EROUT_BIT  5
`define EFFC_ST_STOP_BIT   6

`define EFFC_RESP_OKAY     2'h0
`define EFFC_RESP_SLVERR   2'h2

`define EFFC_ACLK_HZ       50000000
`define EFFC_EXT_MIN_HZ    31250
`define EFFC_EXT_MAX_HZ    5000000
`define EFFC_EXT_LONG_CYC  (`EFFC_ACLK_HZ / `EFFC_EXT_MIN_HZ)
`define EFFC_EXT_SHORT_CYC \
  ((`EFFC_ACLK_HZ + `EFFC_EXT_MAX_HZ - 1) / `EFFC_EXT_MAX_HZ)
`define EFFC_PER_W         11
`define EFFC_FFV_MARGIN    3'h2

`endif

// >>> core/effc_pkg.sv
`default_nettype none
package effc_pkg;

  typedef enum logic [1:0] {
    EFFC_MODE_ENG_INT,
    EFFC_MODE_ENG_EXT,
    EFFC_MODE_BYP_INT,
    EFFC_MODE_BYP_EXT
  } effc_mode_t;

  typedef struct packed {
    logic       ext_ref_stop_enable;
    logic       ext_ref_out_enable;
    logic [1:0] bus_divide;
    logic [2:0] ref_divider;
    logic       ref_select;
    logic [1:0] clock_source_select;
  } effc_ctrl_t;

  typedef struct packed {
    logic ext_ref_clock_out;
    logic fixed_freq_clock;
    logic fixed_freq_valid;
    logic main_clock_out;
  } effc_clk_out_t;

  typedef struct packed {
    effc_ctrl_t    ctrl;
    effc_mode_t    mode;
    logic          awready;
    logic          wready;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    aw_addr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          ref_q;
    logic          ext_q;
    logic [6:0]    ref_cnt;
    logic [10:0]   ext_per;
    logic          ext_slow;
    logic          ext_fast;
    effc_clk_out_t clk;
  } effc_state_t;

endpackage
`default_nettype wire

// >>> test/effc_clock_assertions.sv
`default_nettype none
module effc_clock_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic int_ref_in,
  input wire logic ext_ref_in,
  input wire logic fll_clk_in,
  input wire logic stop_req,
  input wire logic ext_ref_clock_out,
  input wire logic fixed_freq_clock,
  input wire logic fixed_freq_valid,
  input wire logic main_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // The flag may only move as the echo of a control write.
  chk_ffv_write: assert property (
    $changed(fixed_freq_valid) |-> s_axi_bvalid || $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2)) else $error("flag moved without write");
  chk_ffv_reset: assert property (
    $rose(aresetn) |-> fixed_freq_valid) else $error("flag low at start");
  chk_erout_src: assert property (
    ext_ref_clock_out |-> $past(ext_ref_in)) else $error("bad ext out");
  chk_stop_quiet: assert property (
    $past(stop_req) |-> !fixed_freq_clock && !main_clock_out)
    else $error("clock ran in stop");
  chk_main_src: assert property (
    main_clock_out |-> $past(fll_clk_in | int_ref_in | ext_ref_in))
    else $error("main clock from nowhere");
  // A new divider or the end of stop may also start a fixed clock pulse.
  chk_ffclk_src: assert property (
    $rose(fixed_freq_clock) |-> $past(int_ref_in | ext_ref_in)
    || $past(int_ref_in | ext_ref_in, 2) || $past(s_axi_bvalid)
    || $past(stop_req, 2))
    else $error("fixed clock rose without reference");
  chk_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during response");
  chk_r_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (stop_req && ext_ref_clock_out);
  cover property (!fixed_freq_valid);
  cover property (main_clock_out && fixed_freq_clock);
endmodule // effc_clock_assertions
bind effc_clock effc_clock_assertions u_chk (.*);
`default_nettype wire

// >>> test/effc_ref_osc.sv
`default_nettype none
module effc_ref_osc (
  input wire logic        aclk,
  input wire logic [11:0] half_cyc,
  output logic            osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // A crystal runs free, so there is no idle level to model.
  logic [11:0] cnt_r = 12'h000;
  logic        osc_r = 1'h0;
  assign osc = osc_r;
  always @(posedge aclk)
  begin
    if (cnt_r + 12'h001 >= half_cyc)
    begin
      cnt_r <= 12'h000;
      osc_r <= ~osc_r;
    end
    else
      cnt_r <= cnt_r + 12'h001;
  end
endmodule // effc_ref_osc
`default_nettype wire

// >>> test/effc_clock_tb_top.sv
`default_nettype none
module effc_clock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0, aresetn = 1'h0, stop_req = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        int_ref, ext_ref, fll_clk, ext_out, ff_clk, ff_ok, main_out;
  logic [11:0] ext_half = 12'h005;
  int          errors = 0, total_checks = 0;
  always #10 aclk = ~aclk;
  effc_ref_osc u_int (.aclk(aclk), .half_cyc(12'h007), .osc(int_ref));
  effc_ref_osc u_ext (.aclk(aclk), .half_cyc(ext_half), .osc(ext_ref));
  effc_ref_osc u_fll (.aclk(aclk), .half_cyc(12'h002), .osc(fll_clk));
  effc_clock dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .int_ref_in(int_ref), .ext_ref_in(ext_ref), .fll_clk_in(fll_clk),
    .stop_req(stop_req), .ext_ref_clock_out(ext_out),
    .fixed_freq_clock(ff_clk), .fixed_freq_valid(ff_ok),
    .main_clock_out(main_out));
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'h0;
      end
    join
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic wctrl(input logic [1:0] src, input logic sel,
                       input logic [2:0] rd, input logic [1:0] bd,
                       input logic oe, ste);
    logic [1:0] r;
    axi_wr(8'h00, {22'h0, ste, oe, bd, rd, sel, src}, r);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    check(ff_ok, 1'h1);
    axi_rd(8'h00, d, r);
    check(d, 32'h4);
    axi_rd(8'h04, d, r);
    check(d[2:0], 3'h1);
  endtask
  task automatic t_valid_table;
    logic [31:0] d;
    logic [1:0]  r;
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 4; b++)
        for (int v = 0; v < 8; v++)
        begin
          wctrl(m < 2 ? 2'h0 : 2'(m - 1), m == 0 || m == 2, v[2:0],
                b[1:0], 1'h0, 1'h0);
          axi_rd(8'h04, d, r);
          check(ff_ok, m < 2 || v >= b + 2);
          check(d[2:1], m[1:0]);
        end
  endtask
  task automatic follow(input logic [1:0] src, input logic oe, ste, stp);
    logic pe, pm, pf;
    repeat (40)
    begin
      @(posedge aclk);
      pe = ext_ref & oe & (!stp | ste);
      pm = !stp & (src == 2'h1 ? int_ref : src == 2'h2 ? ext_ref : fll_clk);
      pf = !stp & int_ref;
      #1;
      check(ext_out, pe);
      check(main_out, pm);
      check(ff_clk, pf);
    end
    @(posedge aclk);
  endtask
  task automatic t_clock_paths;
    logic [4:0] cs [5] = '{5'b01100, 5'b10101, 5'b10111, 5'b00010, 5'b00100};
    foreach (cs[i])
    begin
      if (i == 4)
        ext_half <= 12'h001;
      wctrl(cs[i][4:3], 1'h1, 3'h0, 2'h0, cs[i][2], cs[i][1]);
      stop_req <= cs[i][0];
      follow(cs[i][4:3], cs[i][2], cs[i][1], cs[i][0]);
    end
    stop_req <= 1'h0;
  endtask
  task automatic t_bus_edges;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h08, 32'h0, r);
    check(r, 2'h2);
    axi_rd(8'h08, d, r);
    check(r, 2'h2);
    axi_wr(8'h04, 32'h0, r);
    check(r, 2'h0);
    wctrl(2'h2, 1'h0, 3'h0, 2'h0, 1'h0, 1'h0);
    wctrl(2'h3, 1'h0, 3'h0, 2'h0, 1'h0, 1'h0);
    axi_rd(8'h04, d, r);
    check(d[2:1], 2'h3);
    check(d[4:3], 2'h2);
  endtask
  task automatic t_fixed_divide;
    logic [31:0] d;
    logic [1:0]  r;
    time         t0;
    @(posedge aclk);
    // Divided reference sits near 34.7 kHz, inside the engaged range.
    ext_half <= 12'h05A;
    wctrl(2'h0, 1'h0, 3'h3, 2'h0, 1'h0, 1'h0);
    // A change of divider may cut the first period short, so skip it.
    repeat (2) @(posedge ff_clk);
    t0 = $time;
    @(posedge ff_clk);
    check(32'(($time - t0) / 20), 32'h5A0);
    axi_rd(8'h04, d, r);
    check(d[6:0], 7'h03);
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_valid_table();
    t_clock_paths();
    t_bus_edges();
    t_fixed_divide();
    tally_and_finish();
  end
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule // effc_clock_tb_top
`default_nettype wire
